// ### verilog/power_mode_and_supply_monitor.sv
/*
  Power-mode controller and supply supervisor with an AXI4-Lite slave.
  Assumes supply comparators, the reset pin and the oscillators outside;
  the wake input comes from the interrupt logic on the same clock.
*/
`include "pwr_cfg.svh"
`default_nettype none
module power_mode_and_supply_monitor
  import pwr_pkg::*;
#(
  parameter int NSUB = 16,
  parameter int SLOW_TICK_CYC = `SLOW_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // AXI4-Lite write
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  // Supply comparators and reset pin
  input wire logic [3:0] por_low_in,
  input wire logic digital_supply_stable_in,
  input wire logic analog_supply_low_in,
  input wire logic digital_supply_low_in,
  input wire logic analog_supply_high_in,
  input wire logic external_reset_pin_n_in,
  // Interrupt logic
  input wire logic wake_irq_in,
  // Reset and power control
  output logic system_reset_out,
  output logic power_up_reset_monitor_en_out,
  output logic main_internal_oscillator_en_out,
  output logic slow_internal_oscillator_en_out,
  output logic clocks_en_out,
  output logic main_regulators_en_out,
  output logic hibernate_regulator_en_out,
  output logic [NSUB-1:0] subsystem_en_out,
  output logic [1:0] power_state_out,
  // Alarms and wake timer
  output logic [3:0] analog_low_trip_out,
  output logic [3:0] digital_low_trip_out,
  output logic [2:0] alarm_event_out,
  output logic wake_timer_irq_out
);
  localparam int DW = $clog2(SLOW_TICK_CYC + 1);
  localparam logic [7:0] POR_CYC = 8'(`POR_MIN_CYC);

  logic [8:0] sync_q;
  logic [3:0] por_low_s;
  logic stable_s, alow_s, dlow_s, ahigh_s, pin_s;
  logic sys_rst_reg, por_mon_en_reg, core_rst, mon_low, pin_low, por_trig;
  logic [7:0] por_cnt_reg;
  pwr_state_t state_reg, state_next;
  logic pend_reg, pend_hib_reg, arm_reg;
  logic [NSUB-1:0] tmpl_act_reg, tmpl_alt_reg;
  trip_code_t alow_code_reg, dlow_code_reg;
  logic [2:0] alm_en_reg;
  logic [7:0] wake_ms_reg, ms_reg;
  logic [DW-1:0] div_reg;
  logic [3:0] status_reg, status_next;
  logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Every asynchronous level passes two flops first; the pin goes in
  // inverted so the flops' reset value is its idle level, no false cause
  sync2 #(.W(9)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in({~external_reset_pin_n_in, analog_supply_high_in,
      digital_supply_low_in, analog_supply_low_in,
      digital_supply_stable_in, por_low_in}),
    .q_out(sync_q)
  );
  assign por_low_s = sync_q[3:0];
  assign stable_s = sync_q[4];
  assign alow_s = sync_q[5];
  assign dlow_s = sync_q[6];
  assign ahigh_s = sync_q[7];
  assign pin_s = sync_q[8];

  // Reset sources: monitor trip, pin, bus reset
  assign mon_low = por_mon_en_reg & (|por_low_s);
  assign pin_low = pin_s;
  assign por_trig = srst_in | mon_low | pin_low;
  assign core_rst = srst_in | sys_rst_reg;

  // Pulse of at least POR_CYC cycles, held while any trigger stays
  always_ff @(posedge clk_in)
  begin
    if (por_trig)
      por_cnt_reg <= POR_CYC;
    else if (por_cnt_reg != 8'h00)
      por_cnt_reg <= por_cnt_reg - 8'h01;
    sys_rst_reg <= por_trig | (por_cnt_reg > 8'h01);
  end

  // Monitor runs while the digital supply is unstable, off once stable and the reset count has run out
  always_ff @(posedge clk_in)
  begin
    if (srst_in || pin_low || !stable_s)
      por_mon_en_reg <= 1'b1;
    else if (por_cnt_reg == 8'h00)
      por_mon_en_reg <= 1'b0;
  end

  // Write channel: address and data taken in either order
  logic aw_take, w_take, aw_have, w_have, do_write, b_done;
  logic aw_hold_next, w_hold_next, bvalid_next;
  logic [7:0] waddr;
  logic [31:0] wd, wmask, wcur, wv;
  logic [3:0] wstrb_w;
  logic wmapped, wr_mode, wr_alarm, wr_stat;
  assign aw_take = axi_awvalid_in & awready_reg;
  assign w_take = axi_wvalid_in & wready_reg;
  assign aw_have = aw_hold_reg | aw_take;
  assign w_have = w_hold_reg | w_take;
  assign do_write = aw_have & w_have & ~bvalid_reg;
  assign b_done = bvalid_reg & axi_bready_in;
  assign aw_hold_next = aw_have & ~do_write;
  assign w_hold_next = w_have & ~do_write;
  assign bvalid_next = do_write | (bvalid_reg & ~axi_bready_in);
  assign waddr = aw_take ? axi_awaddr_in : awaddr_reg;
  assign wd = w_take ? axi_wdata_in : wdata_reg;
  assign wstrb_w = w_take ? axi_wstrb_in : wstrb_reg;
  assign wmask = {{8{wstrb_w[3]}}, {8{wstrb_w[2]}},
    {8{wstrb_w[1]}}, {8{wstrb_w[0]}}};
  // Current contents; follows every register the view reads
  always_comb
  begin
    wcur = reg_view(waddr);
  end
  assign wv = (wcur & ~wmask) | (wd & wmask);
  assign wmapped = is_mapped(waddr);
  assign wr_mode = do_write & (waddr == `OFS_MODE) & wstrb_w[0];
  assign wr_alarm = do_write & (waddr == `OFS_ALARM);
  assign wr_stat = do_write & (waddr == `OFS_STATUS) & wstrb_w[0];

  // Register map view, shared by reads and byte merging
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      `OFS_MODE: v = {29'h0, pend_reg, state_reg};
      `OFS_TMPL_ACT: v = 32'(tmpl_act_reg);
      `OFS_TMPL_ALT: v = 32'(tmpl_alt_reg);
      `OFS_ALARM: v = {21'h0, alm_en_reg, dlow_code_reg, alow_code_reg};
      `OFS_WAKE: v = {24'h0, wake_ms_reg};
      `OFS_STATUS: v = {28'h0, status_reg};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `OFS_MODE || a == `OFS_TMPL_ACT || a == `OFS_TMPL_ALT ||
      a == `OFS_ALARM || a == `OFS_WAKE || a == `OFS_STATUS;
  endfunction

  // Write handshake flops
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= ~aw_hold_next & ~bvalid_next;
      wready_reg <= ~w_hold_next & ~bvalid_next;
      if (aw_take)
        awaddr_reg <= axi_awaddr_in;
      if (w_take)
      begin
        wdata_reg <= axi_wdata_in;
        wstrb_reg <= axi_wstrb_in;
      end
      if (do_write)
        bresp_reg <= wmapped ? `RESP_OKAY : `RESP_DECERR;
    end
  end

  // Read channel: data one cycle after the address is taken
  logic ar_take, rvalid_next;
  assign ar_take = axi_arvalid_in & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~axi_rready_in);
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      arready_reg <= ~rvalid_next;
      if (ar_take)
      begin
        rdata_reg <= reg_view(axi_araddr_in);
        rresp_reg <= is_mapped(axi_araddr_in) ? `RESP_OKAY : `RESP_DECERR;
      end
    end
  end

  // Configuration registers; reserved trip codes leave the field unchanged
  logic [7:0] wake_w;
  assign wake_w = wv[7:0] == 8'h00 ? `WAKE_MIN_MS :
    (wv[7:0] > `WAKE_MAX_MS ? `WAKE_MAX_MS : wv[7:0]);
  always_ff @(posedge clk_in)
  begin
    if (core_rst)
    begin
      tmpl_act_reg <= NSUB'(`TMPL_RST);
      tmpl_alt_reg <= NSUB'(`TMPL_RST);
      alow_code_reg <= `TRIP_RST;
      dlow_code_reg <= `TRIP_RST;
      alm_en_reg <= 3'h0;
      wake_ms_reg <= `WAKE_RST;
    end
    else if (do_write)
    begin
      if (waddr == `OFS_TMPL_ACT)
        tmpl_act_reg <= wv[NSUB-1:0];
      if (waddr == `OFS_TMPL_ALT)
        tmpl_alt_reg <= wv[NSUB-1:0];
      if (wr_alarm && wv[3:0] <= `TRIP_CODE_MAX)
        alow_code_reg <= wv[3:0];
      if (wr_alarm && wv[7:4] <= `TRIP_CODE_MAX)
        dlow_code_reg <= wv[7:4];
      if (wr_alarm)
        alm_en_reg <= wv[10:8];
      if (waddr == `OFS_WAKE)
        wake_ms_reg <= wake_w;
    end
  end

  // Wake timer: core-clock tick divider and millisecond count
  logic tick, wake_tmr;
  assign tick = div_reg == DW'(SLOW_TICK_CYC - 1);
  assign wake_tmr = (state_reg == pwr_sleep) & tick &
    (ms_reg + 8'h01 >= wake_ms_reg);
  always_ff @(posedge clk_in)
  begin
    if (core_rst || state_reg != pwr_sleep || tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + DW'(1);
    if (core_rst || state_reg != pwr_sleep || wake_tmr)
      ms_reg <= 8'h00;
    else if (tick)
      ms_reg <= ms_reg + 8'h01;
  end

  // Power state transitions
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      pwr_active:
        if (wr_mode && wv[1:0] == `MODE_ALT)
          state_next = pwr_alt_active;
      pwr_alt_active:
        if (wake_irq_in || (wr_mode && wv[1:0] == `MODE_ACTIVE))
          state_next = pwr_active;
      pwr_sleep:
        if (wake_tmr)
          state_next = pwr_active;
      pwr_hibernate:
        state_next = pwr_hibernate;
    endcase
    if (b_done && pend_reg && state_reg != pwr_sleep &&
        state_reg != pwr_hibernate)
      state_next = pend_hib_reg ? pwr_hibernate : pwr_sleep;
  end

  // State, pending low-power request and wake re-arm
  always_ff @(posedge clk_in)
  begin
    if (core_rst)
    begin
      state_reg <= pwr_active;
      pend_reg <= 1'b0;
      pend_hib_reg <= 1'b0;
      arm_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      arm_reg <= wake_tmr;
      if (wr_mode && wv[1])
      begin
        pend_reg <= 1'b1;
        pend_hib_reg <= wv[0];
      end
      else if (b_done)
        pend_reg <= 1'b0;
    end
  end

  // Supply alarms run only after reset and in the two run states
  logic alarm_run;
  assign alarm_run = ~sys_rst_reg &
    (state_reg == pwr_active || state_reg == pwr_alt_active);
  alarm_if alm_a ();
  alarm_if alm_d ();
  alarm_if alm_h ();
  assign alm_a.enable = alarm_run & alm_en_reg[0];
  assign alm_d.enable = alarm_run & alm_en_reg[1];
  assign alm_h.enable = alarm_run & alm_en_reg[2];
  assign alm_a.level = alow_s;
  assign alm_d.level = dlow_s;
  assign alm_h.level = ahigh_s;
  assign alm_a.arm = arm_reg;
  assign alm_d.arm = arm_reg;
  assign alm_h.arm = arm_reg;
  supply_alarm_channel u_alow (
    .clk_in(clk_in), .srst_in(core_rst), .alm(alm_a));
  supply_alarm_channel u_dlow (
    .clk_in(clk_in), .srst_in(core_rst), .alm(alm_d));
  supply_alarm_channel u_ahigh (
    .clk_in(clk_in), .srst_in(core_rst), .alm(alm_h));

  // Status: supply power-on clears, events set, write-one clears; set wins
  logic [3:0] st_set;
  assign st_set = {alm_h.fire, alm_d.fire, alm_a.fire, pin_low};
  assign status_next = (status_reg & ~(wr_stat ? wv[3:0] : 4'h0)) | st_set;
  always_ff @(posedge clk_in)
  begin
    if (srst_in || mon_low)
      status_reg <= 4'h0;
    else
      status_reg <= status_next;
  end

  // Power outputs follow the next state so they line up with it
  logic run_next;
  assign run_next = state_next == pwr_active || state_next == pwr_alt_active;
  always_ff @(posedge clk_in)
  begin
    power_state_out <= core_rst ? 2'h0 : state_next;
    subsystem_en_out <= core_rst ? '0 :
      (state_next == pwr_active ? tmpl_act_reg :
      (state_next == pwr_alt_active ? tmpl_alt_reg : '0));
    clocks_en_out <= core_rst | state_next != pwr_hibernate;
    slow_internal_oscillator_en_out <= core_rst |
      state_next != pwr_hibernate;
    main_regulators_en_out <= core_rst | state_next != pwr_hibernate;
    hibernate_regulator_en_out <= 1'b1;
    main_internal_oscillator_en_out <= ~(|por_low_s) &
      (core_rst | run_next);
    wake_timer_irq_out <= ~core_rst & wake_tmr;
  end

  assign system_reset_out = sys_rst_reg;
  assign power_up_reset_monitor_en_out = por_mon_en_reg;
  assign analog_low_trip_out = alow_code_reg;
  assign digital_low_trip_out = dlow_code_reg;
  assign alarm_event_out = {alm_h.fire, alm_d.fire, alm_a.fire};
  assign axi_awready_out = awready_reg;
  assign axi_wready_out = wready_reg;
  assign axi_bvalid_out = bvalid_reg;
  assign axi_bresp_out = bresp_reg;
  assign axi_arready_out = arready_reg;
  assign axi_rvalid_out = rvalid_reg;
  assign axi_rdata_out = rdata_reg;
  assign axi_rresp_out = rresp_reg;

  // Checks: reset pulse length counter
  logic [7:0] rst_len;
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !sys_rst_reg)
      rst_len <= 8'h00;
    else if (rst_len != 8'hFF)
      rst_len <= rst_len + 8'h01;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_por_min_width: assert property ($fell(sys_rst_reg) |->
    rst_len >= POR_CYC) else $error("reset pulse too short");
  a_pin_holds_reset: assert property (pin_low |=> sys_rst_reg)
    else $error("pin low without system reset");
  a_hib_exit_reset: assert property (state_reg == pwr_hibernate &&
    !core_rst |=> state_reg == pwr_hibernate)
    else $error("hibernate left without reset");
  a_hib_power_off: assert property (state_reg == pwr_hibernate |->
    !clocks_en_out && !main_regulators_en_out && hibernate_regulator_en_out)
    else $error("hibernate power outputs wrong");
  a_sleep_subsys_off: assert property (state_reg == pwr_sleep |->
    subsystem_en_out == '0 && slow_internal_oscillator_en_out)
    else $error("sleep leaves subsystems on");
  a_active_template: assert property (state_reg == pwr_active &&
    !$past(core_rst) |-> subsystem_en_out == $past(tmpl_act_reg))
    else $error("active subsystems differ from template");
  a_alarm_gated: assert property (alarm_event_out != 3'h0 |->
    $past(alarm_run)) else $error("alarm fired while disabled");
  a_sleep_after_bresp: assert property (state_reg != pwr_sleep ##1
    state_reg == pwr_sleep |-> $past(b_done))
    else $error("sleep entered before bus answer");
  a_trip_code_legal: assert property (
    alow_code_reg <= `TRIP_CODE_MAX && dlow_code_reg <= `TRIP_CODE_MAX)
    else $error("reserved trip code");
  a_status_set_wins: assert property (alarm_event_out[0] && !mon_low
    |=> status_reg[`ST_ALOW]) else $error("alarm event lost");
  a_wake_to_active: assert property (wake_timer_irq_out |->
    state_reg == pwr_active && $past(state_reg) == pwr_sleep)
    else $error("wake timer without return to active");
  c_sleep_entry: cover property (state_reg == pwr_sleep);
  c_timer_wake: cover property (wake_timer_irq_out);
  c_hib_entry: cover property (state_reg == pwr_hibernate);
  c_alarm_rearm: cover property (arm_reg ##1 alarm_event_out != 3'h0);
endmodule
`default_nettype wire

// ### verilog/pwr_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the power-mode
  controller. Assumes a 125 MHz core clock and a byte-addressed register bus.
*/
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_TMPL_ACT 8'h04
`define OFS_TMPL_ALT 8'h08
`define OFS_ALARM 8'h0C
`define OFS_WAKE 8'h10
`define OFS_STATUS 8'h14
// Mode codes written to and read from the mode register
`define MODE_ACTIVE 2'h0
`define MODE_ALT 2'h1
`define MODE_SLEEP 2'h2
`define MODE_HIB 2'h3
// Status bits
`define ST_PIN_RST 0
`define ST_ALOW 1
`define ST_DLOW 2
`define ST_AHIGH 3
// Reset values
`define TMPL_RST 32'hFFFF_FFFF
`define TRIP_RST 4'h0
`define WAKE_RST 8'h80
// Low trip code n selects BASE + n * STEP millivolts
`define TRIP_BASE_MV 2450
`define TRIP_STEP_MV 250
`define TRIP_CODE_MAX 4'hC
`define HIGH_TRIP_MV 5750
// Wake interval limits in milliseconds
`define WAKE_MIN_MS 8'h01
`define WAKE_MAX_MS 8'h80
// Timing
`define CLK_PERIOD_NS 8
`define CLK_MHZ 125
`define POR_MIN_NS 100
`define POR_MIN_CYC ((`POR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_TICK_US 1000
`define SLOW_TICK_CYC (`SLOW_TICK_US * `CLK_MHZ)
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ### verilog/pwr_pkg.sv
/*
  Types of the power-mode controller.
  Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package pwr_pkg;
  // Four power states, highest consumption first
  typedef enum logic [1:0] {
    pwr_active, pwr_alt_active, pwr_sleep, pwr_hibernate
  } pwr_state_t;
  typedef logic [3:0] trip_code_t;
endpackage
`default_nettype wire

// ### verilog/alarm_if.sv
/*
  Connection between the controller and one supply alarm channel.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface alarm_if;
  logic enable;
  logic arm;
  logic level;
  logic fire;
  modport ctrl (output enable, output arm, output level, input fire);
  modport chan (input enable, input arm, input level, output fire);
endinterface
`default_nettype wire

// ### verilog/sync2.sv
/*
  Two flip-flop synchroniser for a bus of independent levels.
  Assumes each bit changes slowly compared with the clock.
*/
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      meta_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      meta_reg <= d_in;
      q_reg <= meta_reg;
    end
  end

  assign q_out = q_reg;
endmodule
`default_nettype wire

// ### verilog/supply_alarm_channel.sv
/*
  One supply alarm: reports a comparator level once per enabled excursion and again on a re-arm.
  Assumes a synchronised level and an enable from the controller.
*/
`default_nettype none
module supply_alarm_channel (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Controller side
  alarm_if.chan alm
);
  logic reported_reg;
  logic fire_reg;
  logic fire_next;

  // Fire once; a re-arm lets a standing level report again at once
  assign fire_next = alm.enable & alm.level & (~reported_reg | alm.arm);

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      reported_reg <= 1'b0;
      fire_reg <= 1'b0;
    end
    else
    begin
      reported_reg <= alm.enable & alm.level;
      fire_reg <= fire_next;
    end
  end

  assign alm.fire = fire_reg;
endmodule
`default_nettype wire

// ### sim/supply_model.sv
/*
  Supply comparators seen by the block.
  Assumes the bench sets the wanted levels.
*/
`default_nettype none
module supply_model (
  // Wanted conditions
  input wire logic up_in,
  input wire logic [2:0] alarm_in,
  // Comparator levels
  output logic [3:0] por_low_out,
  output logic stable_out,
  output logic [2:0] alarm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every supply below trip while down
  assign por_low_out = {4{~up_in}};
  assign stable_out = up_in;
  assign alarm_out = alarm_in & {3{up_in}};
endmodule
`default_nettype wire

// ### sim/power_mode_and_supply_monitor_test.sv
/*
  Bench: AXI4-Lite master tasks, supply model, random codes.
  Assumes the design files and the config header.
*/
`include "pwr_cfg.svh"
`default_nettype none
module power_mode_and_supply_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, srst_in, axi_awvalid_in, axi_awready_out, axi_wvalid_in;
  logic axi_wready_out, axi_bvalid_out, axi_bready_in, axi_arvalid_in;
  logic axi_arready_out, axi_rvalid_out, axi_rready_in, wake_irq_in, up;
  logic [7:0] axi_awaddr_in, axi_araddr_in;
  logic [31:0] axi_wdata_in, axi_rdata_out, d;
  logic [3:0] axi_wstrb_in, por_low_in, analog_low_trip_out, u, te;
  logic [3:0] digital_low_trip_out;
  logic [1:0] axi_bresp_out, axi_rresp_out, power_state_out, r;
  logic digital_supply_stable_in, analog_supply_low_in, digital_supply_low_in;
  logic analog_supply_high_in, external_reset_pin_n_in, system_reset_out;
  logic power_up_reset_monitor_en_out, main_internal_oscillator_en_out;
  logic slow_internal_oscillator_en_out, clocks_en_out, main_regulators_en_out;
  logic hibernate_regulator_en_out, wake_timer_irq_out;
  logic [15:0] subsystem_en_out;
  logic [2:0] alarm_event_out, alm, acc;
  int n_mismatch, n_compared, cyc, k;
  // Far side and device
  supply_model sup_u (.up_in(up), .alarm_in(alm), .por_low_out(por_low_in),
    .stable_out(digital_supply_stable_in), .alarm_out({analog_supply_high_in,
    digital_supply_low_in, analog_supply_low_in}));
  power_mode_and_supply_monitor #(.SLOW_TICK_CYC(8)) dut_u (.*);
  // Clock
  initial
  begin
    clk_in = 0;
    forever #4 clk_in = ~clk_in;
  end
  // Hang limit
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] exp_trip(input int c, input logic [3:0] p);
    return (c > 12) ? p : c[3:0];
  endfunction
  // Bus write, response kept in r
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_awaddr_in <= a;
    axi_wdata_in <= v;
    axi_awvalid_in <= 1;
    axi_wvalid_in <= 1;
    axi_bready_in <= 1;
    do
    begin
      @(posedge clk_in);
      if (axi_awready_out)
        axi_awvalid_in <= 0;
      if (axi_wready_out)
        axi_wvalid_in <= 0;
    end while (axi_bvalid_out !== 1);
    r = axi_bresp_out;
    axi_bready_in <= 0;
    @(posedge clk_in);
  endtask
  // Bus read into d and r
  task automatic rd(input logic [7:0] a);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1;
    axi_rready_in <= 1;
    do
    begin
      @(posedge clk_in);
      if (axi_arready_out)
        axi_arvalid_in <= 0;
    end while (axi_rvalid_out !== 1);
    d = axi_rdata_out;
    r = axi_rresp_out;
    axi_rready_in <= 0;
    @(posedge clk_in);
  endtask
  // Watch events and wake pulses
  task automatic obs(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      acc |= alarm_event_out;
      k += wake_timer_irq_out;
    end
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(21));
    srst_in = 1;
    {axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in} = 0;
    {axi_rready_in, wake_irq_in, alm, te, acc} = 0;
    {axi_awaddr_in, axi_araddr_in, axi_wdata_in} = 0;
    axi_wstrb_in = 4'hF;
    external_reset_pin_n_in = 1;
    up = 1;
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    while (system_reset_out !== 0) @(posedge clk_in);
    // Outputs reload from the templates one edge after reset falls
    @(posedge clk_in);
    chk(power_state_out, `MODE_ACTIVE);
    chk(subsystem_en_out, 16'hFFFF);
    chk(power_up_reset_monitor_en_out, 1'h0);
    rd(`OFS_WAKE);
    chk(d, `WAKE_RST);
    rd(8'h40);
    chk(r, `RESP_DECERR);
    d = $urandom;
    wr(`OFS_TMPL_ACT, d);
    chk(subsystem_en_out, d[15:0]);
    wr(`OFS_MODE, `MODE_ALT);
    chk(power_state_out, `MODE_ALT);
    wake_irq_in <= 1;
    obs(3);
    wake_irq_in <= 0;
    chk(power_state_out, `MODE_ACTIVE);
    for (int c = 0; c < 16; c++)
    begin
      u = $urandom_range(12);
      wr(`OFS_ALARM, 32'h0000_0500 | {24'h0, u, c[3:0]});
      te = exp_trip(c, te);
      chk(analog_low_trip_out, te);
      chk(digital_low_trip_out, u);
    end
    alm <= 3'h7;
    obs(8);
    chk(acc, 3'h5);
    rd(`OFS_STATUS);
    chk(d[3:0], 4'hA);
    wr(`OFS_WAKE, 32'h0000_0000);
    {acc, k} = 0;
    wr(`OFS_MODE, `MODE_SLEEP);
    chk(power_state_out, `MODE_SLEEP);
    chk({subsystem_en_out, slow_internal_oscillator_en_out}, 17'h1);
    obs(30);
    chk(k, 1);
    chk(acc[0], 1'h1);
    chk(power_state_out, `MODE_ACTIVE);
    wr(`OFS_MODE, `MODE_HIB);
    wake_irq_in <= 1;
    obs(4);
    chk(power_state_out, `MODE_HIB);
    chk({clocks_en_out, main_regulators_en_out,
      hibernate_regulator_en_out}, 3'h1);
    {wake_irq_in, external_reset_pin_n_in} <= 0;
    obs(4);
    chk(system_reset_out, 1'h1);
    external_reset_pin_n_in <= 1;
    k = 0;
    while (system_reset_out !== 0)
    begin
      @(posedge clk_in);
      k++;
    end
    chk(k >= `POR_MIN_CYC, 1'h1);
    chk(power_state_out, `MODE_ACTIVE);
    rd(`OFS_STATUS);
    chk(d[0], 1'h1);
    {up, alm} <= 0;
    obs(8);
    chk({system_reset_out, main_internal_oscillator_en_out}, 2'h2);
    up <= 1;
    while (system_reset_out !== 0) @(posedge clk_in);
    rd(`OFS_STATUS);
    chk(d[3:0], 4'h0);
    complete_run();
  end
endmodule
`default_nettype wire
